//--- efs_asserts.sv
// Concurrent checks on the link between the master end and the controller end.
// Assumes it is instantiated beside the interface and fed its signals by name.
module efs_asserts
    import efs_pkg::*;
(
    input wire logic                 sys_clk_in,
    input wire logic                 reset_in,
    input wire logic                 req,
    input wire logic                 we,
    input wire logic                 fetch,
    input wire logic                 ack,
    input wire logic                 cmd_wr,
    input wire logic [31:0]          cmd_data,
    input wire logic [1:0]           wait_states,
    input wire logic                 status_rd,
    input wire logic                 ready,
    input wire logic                 prog_err,
    input wire logic                 lock_err,
    input wire logic [NUM_LOCKS-1:0] lock_status
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    // Region of the last accepted command, held while it runs to completion.
    logic [3:0] region_r;
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            region_r <= 4'h0;
        end else if (cmd_wr && ready) begin
            region_r <= cmd_data[17:14];
        end
    end

    sequence keyed_s(logic [3:0] code);
        cmd_wr && ready && cmd_data[31:24] == CMD_KEY && cmd_data[3:0] == code;
    endsequence
    sequence rd_start_s;
        $rose(req) && !we;
    endsequence

    read_zero_a: assert property (rd_start_s ##0 wait_states == 2'h0 |-> ack)
        else $error("zero-wait read not answered in its own cycle");
    data_read_a: assert property (rd_start_s ##0 (!fetch && wait_states == 2'h2) |-> !ack [*2] ##1 ack)
        else $error("data read with two waits has wrong length");
    write_one_a: assert property ($rose(req) && we && wait_states == 2'h0 |-> !ack ##1 ack)
        else $error("write with zero waits has wrong length");
    write_three_a: assert property ($rose(req) && we && wait_states == 2'h3 |-> !ack [*3] ##1 ack)
        else $error("write with three waits has wrong length");
    ready_drop_a: assert property (cmd_wr && ready |=> !ready)
        else $error("ready stayed high after a command write");
    bad_code_a: assert property (cmd_wr && ready && !(cmd_data[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hB, 4'hD, 4'hF}) |-> ##[1:700] prog_err)
        else $error("invalid command did not flag a programming error");
    err_clear_a: assert property (status_rd && ready && !cmd_wr |=> !prog_err && !lock_err)
        else $error("status read did not clear the error flags");
    erase_locked_a: assert property (keyed_s(CMD_ERASE_ALL) ##0 (|lock_status) |-> ##[1:700] lock_err)
        else $error("erase all with a lock set did not flag a lock error");
    lock_set_a: assert property (keyed_s(CMD_LOCK) |-> ##[1:700] lock_status[region_r])
        else $error("lock command did not set the region status");
    unlock_clr_a: assert property (keyed_s(CMD_UNLOCK) |-> ##[1:700] !lock_status[region_r])
        else $error("unlock command did not clear the region status");
endmodule // efs_asserts

//--- efs_ctrl.sv
// Embedded flash controller end: read path with prefetch, write latch,
// and the key-protected command sequencer. Assumes one clock.
module efs_ctrl
    import efs_pkg::*;
(
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    efs_if.ctrl       bus,
    output logic      irq_out,
    input  wire logic ready_irq_en_in,
    input  wire logic lock_irq_en_in,
    input  wire logic prog_irq_en_in
);
    // ****************************************************
    // Storage
    // ****************************************************
    logic [31:0] flash_mem [2**FLASH_WORD_AW];
    logic [31:0] latch_mem [PAGE_WORDS];
    logic [NUM_LOCKS-1:0] lock_cells_r;
    logic [NUM_GP-1:0]    gp_cells_r;
    logic                 secure_r;

    typedef enum logic [1:0] {EFS_IDLE, EFS_WAIT, EFS_BUSY} efs_state_t;
    efs_state_t  state_r;
    logic [3:0]  cmd_r;
    logic [PAGE_AW-1:0] page_r;
    logic [$clog2(PROG_CYCLES+1)-1:0] busy_cnt_r;
    logic [LATCH_AW:0] prog_idx_r;
    logic        ready_r, prog_err_r, lock_err_r;

    // ****************************************************
    // Read path
    // ****************************************************
    logic [FLASH_WORD_AW-1:0] word_addr;
    logic [FLASH_WORD_AW-1:0] last_addr_r;
    logic        seq_valid_r, odd_r, busy_acc_r;
    logic [31:0] buf_r [2];
    logic [2:0]  acc_cycles;
    logic        start, done;

    assign word_addr = bus.addr[FLASH_WORD_AW+1:2];

    always_comb begin
        acc_cycles = {1'b0, bus.wait_states};
        if (bus.we) begin
            acc_cycles = (bus.wait_states == MAX_WAIT) ? 3'h3 : acc_cycles + 3'h1;
        end else if (bus.fetch && seq_valid_r && word_addr == last_addr_r + 1'b1) begin
            if (bus.wait_states == 2'h1) begin
                acc_cycles = 3'h0;
            end else if (odd_r) begin
                acc_cycles = 3'h0;
            end
        end
    end

    assign start = bus.req && !busy_acc_r;
    efs_wait_timer u_timer (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .start_in   (start),
        .cycles_in  (acc_cycles),
        .done_out   (done)
    );
    assign bus.ack = (start || busy_acc_r) && done;

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            busy_acc_r <= 1'b0;
        end else if (bus.ack) begin
            busy_acc_r <= 1'b0;
        end else if (start) begin
            busy_acc_r <= 1'b1;
        end
    end

    // Sequential code fetches alternate long and short, except with one wait state where all after the first are short; data reads break the run.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            seq_valid_r <= 1'b0;
            odd_r       <= 1'b0;
            last_addr_r <= '0;
        end else if (bus.ack && !bus.we) begin
            if (bus.fetch && seq_valid_r && word_addr == last_addr_r + 1'b1) begin
                odd_r <= !odd_r;
            end else begin
                odd_r <= 1'b1;
            end
            seq_valid_r <= bus.fetch;
            last_addr_r <= word_addr;
        end
    end

    // Buffer pair: current word and the one fetched ahead for code.
    always_ff @(posedge sys_clk_in) begin
        if (bus.ack && !bus.we) begin
            buf_r[0] <= flash_mem[word_addr];
            buf_r[1] <= flash_mem[word_addr + 1'b1];
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            bus.rdata <= 32'h0000_0000;
        end else if (bus.ack && !bus.we) begin
            unique case (bus.size)
                EFS_SIZE_BYTE: bus.rdata <= {24'h00_0000,
                    flash_mem[word_addr][8*bus.addr[1:0] +: 8]};
                EFS_SIZE_HALF: bus.rdata <= {16'h0000,
                    flash_mem[word_addr][16*bus.addr[1] +: 16]};
                default:       bus.rdata <= flash_mem[word_addr];
            endcase
        end
    end

    // ****************************************************
    // Write latch
    // ****************************************************
    always_ff @(posedge sys_clk_in) begin
        if (bus.ack && bus.we) begin
            latch_mem[bus.addr[7:2]] <= bus.wdata;
        end
    end

    // ****************************************************
    // Command sequencer
    // ****************************************************
    logic [7:0] key_f;
    logic [3:0] code_f;
    logic       code_ok, page_locked, any_lock;
    assign key_f  = bus.cmd_data[KEY_LSB +: 8];
    assign code_f = bus.cmd_data[3:0];
    assign page_locked = lock_cells_r[bus.cmd_data[PAGE_LSB+LOCK_SHIFT +: 4]];
    assign any_lock = |lock_cells_r;
    always_comb begin
        unique case (code_f)
            CMD_WRITE_PAGE, CMD_LOCK, CMD_WRITE_LOCK, CMD_UNLOCK,
            CMD_ERASE_ALL, CMD_SET_GP, CMD_CLR_GP, CMD_SECURE: code_ok = 1'b1;
            default: code_ok = 1'b0;
        endcase
    end

    logic accept_cmd, good_cmd;
    assign accept_cmd = bus.cmd_wr && state_r == EFS_IDLE;
    assign good_cmd = accept_cmd && key_f == CMD_KEY && code_ok
        && bus.cmd_data[7:4] == 4'h0;

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r    <= EFS_IDLE;
            cmd_r      <= 4'h0;
            page_r     <= '0;
            busy_cnt_r <= '0;
            prog_idx_r <= '0;
        end else begin
            unique case (state_r)
                EFS_IDLE: if (accept_cmd) begin
                    state_r    <= EFS_WAIT;
                    cmd_r      <= good_cmd ? code_f : 4'h0;
                    page_r     <= bus.cmd_data[PAGE_LSB +: PAGE_AW];
                    busy_cnt_r <= '0;
                    prog_idx_r <= '0;
                end
                EFS_WAIT: begin
                    busy_cnt_r <= busy_cnt_r + 1'b1;
                    if (busy_cnt_r == ($bits(busy_cnt_r))'(PROG_CYCLES)) begin
                        state_r <= EFS_BUSY;
                    end
                end
                EFS_BUSY: begin
                    prog_idx_r <= prog_idx_r + 1'b1;
                    if (prog_idx_r == (LATCH_AW+1)'(PAGE_WORDS - 1)) begin
                        state_r <= EFS_IDLE;
                    end
                end
            endcase
        end
    end

    logic lock_hit_r, erase_bad_r;
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            lock_hit_r  <= 1'b0;
            erase_bad_r <= 1'b0;
        end else if (good_cmd) begin
            lock_hit_r  <= page_locked;
            erase_bad_r <= any_lock;
        end
    end

    logic is_prog;
    assign is_prog = (cmd_r == CMD_WRITE_PAGE || cmd_r == CMD_WRITE_LOCK) && !lock_hit_r;

    logic finish;
    assign finish = state_r == EFS_BUSY && prog_idx_r == (LATCH_AW+1)'(PAGE_WORDS - 1);

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            lock_cells_r <= '0;
            gp_cells_r   <= '0;
            secure_r     <= 1'b0;
        end else if (finish) begin
            unique case (cmd_r)
                CMD_LOCK:       lock_cells_r[page_r[PAGE_AW-1:LOCK_SHIFT]] <= 1'b1;
                CMD_WRITE_LOCK: if (!lock_hit_r) begin
                    lock_cells_r[page_r[PAGE_AW-1:LOCK_SHIFT]] <= 1'b1;
                end
                CMD_UNLOCK:     lock_cells_r[page_r[PAGE_AW-1:LOCK_SHIFT]] <= 1'b0;
                CMD_SET_GP:     if (page_r < PAGE_AW'(NUM_GP)) begin
                    gp_cells_r[page_r[GP_AW-1:0]] <= 1'b1;
                end
                CMD_CLR_GP:     if (page_r < PAGE_AW'(NUM_GP)) begin
                    gp_cells_r[page_r[GP_AW-1:0]] <= 1'b0;
                end
                CMD_SECURE:     secure_r <= 1'b1;
                default:        ;
            endcase
        end
    end

    // One process owns the array so that it has a single driver. Erase all runs only
    // when no region is locked; page program takes one latch word a cycle.
    always_ff @(posedge sys_clk_in) begin
        if (finish && cmd_r == CMD_ERASE_ALL && !erase_bad_r) begin
            for (int i = 0; i < 2**FLASH_WORD_AW; i++) begin
                flash_mem[i] <= ERASED_WORD;
            end
        end else if (state_r == EFS_BUSY && is_prog) begin
            flash_mem[{page_r, prog_idx_r[LATCH_AW-1:0]}] <= bus.no_erase
                ? (flash_mem[{page_r, prog_idx_r[LATCH_AW-1:0]}]
                   & latch_mem[prog_idx_r[LATCH_AW-1:0]])
                : latch_mem[prog_idx_r[LATCH_AW-1:0]];
        end
    end

    // ****************************************************
    // Status flags
    // ****************************************************
    logic lock_err_set;
    assign lock_err_set = finish && ((lock_hit_r &&
        (cmd_r == CMD_WRITE_PAGE || cmd_r == CMD_WRITE_LOCK))
        || (cmd_r == CMD_ERASE_ALL && erase_bad_r));

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ready_r <= 1'b1;
        end else if (accept_cmd) begin
            ready_r <= 1'b0;
        end else if (finish) begin
            ready_r <= 1'b1;
        end
    end

    // A set in the same cycle as the status read wins, so no event is lost.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            prog_err_r <= 1'b0;
            lock_err_r <= 1'b0;
        end else begin
            if (accept_cmd && !good_cmd) begin
                prog_err_r <= 1'b1;
            end else if (bus.status_rd) begin
                prog_err_r <= 1'b0;
            end
            if (lock_err_set) begin
                lock_err_r <= 1'b1;
            end else if (bus.status_rd) begin
                lock_err_r <= 1'b0;
            end
        end
    end

    assign bus.ready       = ready_r;
    assign bus.prog_err    = prog_err_r;
    assign bus.lock_err    = lock_err_r;
    assign bus.lock_status = lock_cells_r;
    assign bus.gp_bits     = gp_cells_r;
    assign bus.secure      = secure_r;
    assign irq_out = (ready_r && ready_irq_en_in) || (lock_err_r && lock_irq_en_in)
        || (prog_err_r && prog_irq_en_in);
endmodule // efs_ctrl

//--- efs_if.sv
// Interface joining the bus master end to the embedded flash controller end.
// Assumes both ends share sys_clk_in.
interface efs_if;
    import efs_pkg::*;
    logic                req;
    logic                we;
    logic                fetch;
    efs_size_t           size;
    logic [ADDR_W-1:0]   addr;
    logic [31:0]         wdata;
    logic                ack;
    logic [31:0]         rdata;
    logic                cmd_wr;
    logic [31:0]         cmd_data;
    logic [1:0]          wait_states;
    logic                no_erase;
    logic                status_rd;
    logic                ready;
    logic                prog_err;
    logic                lock_err;
    logic [NUM_LOCKS-1:0] lock_status;
    logic [NUM_GP-1:0]   gp_bits;
    logic                secure;

    modport ctrl (input req, we, fetch, size, addr, wdata, cmd_wr, cmd_data,
                  wait_states, no_erase, status_rd,
                  output ack, rdata, ready, prog_err, lock_err, lock_status, gp_bits, secure);
    modport master (output req, we, fetch, size, addr, wdata, cmd_wr, cmd_data,
                    wait_states, no_erase, status_rd,
                    input ack, rdata, ready, prog_err, lock_err, lock_status, gp_bits, secure);
endinterface

//--- efs_master.sv
// Bus master end: turns user requests into flash accesses and keyed commands.
// Assumes the user waits for done before the next request.
module efs_master
    import efs_pkg::*;
(
    input  wire logic                sys_clk_in,
    input  wire logic                reset_in,
    efs_if.master                    bus,
    input  wire logic                acc_req_in,
    input  wire logic                acc_we_in,
    input  wire logic                acc_fetch_in,
    input  wire efs_size_t           acc_size_in,
    input  wire logic [ADDR_W-1:0]   acc_addr_in,
    input  wire logic [31:0]         acc_wdata_in,
    input  wire logic                cmd_req_in,
    input  wire logic [3:0]          cmd_code_in,
    input  wire logic [PAGE_AW-1:0]  cmd_page_in,
    input  wire logic [1:0]          wait_states_in,
    input  wire logic                no_erase_in,
    input  wire logic                status_rd_in,
    output logic                     acc_done_out,
    output logic [31:0]              acc_rdata_out,
    output logic                     ready_out
);
    logic pend_r;

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pend_r <= 1'b0;
        end else if (bus.ack) begin
            pend_r <= 1'b0;
        end else if (acc_req_in) begin
            pend_r <= 1'b1;
        end
    end

    assign bus.req   = acc_req_in || pend_r;
    assign bus.we    = acc_we_in;
    assign bus.fetch = acc_fetch_in && !acc_we_in;
    assign bus.size  = acc_we_in ? EFS_SIZE_WORD : acc_size_in;
    assign bus.addr  = acc_addr_in;
    assign bus.wdata = acc_wdata_in;
    assign bus.cmd_wr   = cmd_req_in;
    assign bus.cmd_data = {CMD_KEY, 6'h00, cmd_page_in, 4'h0, cmd_code_in};
    assign bus.wait_states = wait_states_in;
    assign bus.no_erase    = no_erase_in;
    assign bus.status_rd   = status_rd_in;
    assign acc_done_out    = bus.ack;
    assign acc_rdata_out   = bus.rdata;
    assign ready_out       = bus.ready;
endmodule // efs_master

//--- efs_pkg.sv
// Constants and types for the embedded flash sequencer.
// Assumes a single 50 MHz master clock shared by both ends.
package efs_pkg;

    localparam int ADDR_W        = 20;
    localparam int PAGE_WORDS    = 64;
    localparam int LATCH_AW      = 6;
    localparam int NUM_PAGES     = 1024;
    localparam int PAGE_AW       = 10;
    localparam int FLASH_WORD_AW = 16;
    localparam int NUM_LOCKS     = 16;
    localparam int LOCK_SHIFT    = 6;
    localparam int NUM_GP        = 3;
    localparam int GP_AW         = 2;

    localparam logic [7:0] CMD_KEY        = 8'h5A;
    localparam int         KEY_LSB        = 24;
    localparam int         PAGE_LSB       = 8;
    localparam logic [3:0] CMD_WRITE_PAGE = 4'h1;
    localparam logic [3:0] CMD_LOCK       = 4'h2;
    localparam logic [3:0] CMD_WRITE_LOCK = 4'h3;
    localparam logic [3:0] CMD_UNLOCK     = 4'h4;
    localparam logic [3:0] CMD_ERASE_ALL  = 4'h8;
    localparam logic [3:0] CMD_SET_GP     = 4'hB;
    localparam logic [3:0] CMD_CLR_GP     = 4'hD;
    localparam logic [3:0] CMD_SECURE     = 4'hF;

    localparam logic [1:0]  MAX_WAIT    = 2'h3;
    localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

    localparam real PROG_TIME_US = 6.0;
    localparam int  CLK_MHZ      = 50;
    localparam int  PROG_CYCLES  = int'(PROG_TIME_US * CLK_MHZ);

    typedef enum logic [1:0] {EFS_SIZE_BYTE, EFS_SIZE_HALF, EFS_SIZE_WORD} efs_size_t;

endpackage

//--- efs_wait_timer.sv
// Access length counter: stretches a flash access by the programmed waits.
// Assumes start pulses only when idle.
module efs_wait_timer
    import efs_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       reset_in,
    input  wire logic       start_in,
    input  wire logic [2:0] cycles_in,
    output logic            done_out
);
    logic [2:0] count_r;

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            count_r <= 3'h0;
        end else if (start_in) begin
            count_r <= cycles_in;
        end else if (count_r != 3'h0) begin
            count_r <= count_r - 3'h1;
        end
    end

    assign done_out = start_in ? (cycles_in == 3'h0) : (count_r == 3'h1);
endmodule // efs_wait_timer

//--- embedded_flash_sequencer_tb.sv
// Self-checking bench: master end and controller end joined by the interface.
// Assumes package, interface, both ends and the checker are compiled first.
module embedded_flash_sequencer_tb
    import efs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic             sys_clk_in = 1'b0;
    logic             reset_in;
    logic             acc_req_in, acc_we_in, acc_fetch_in, cmd_req_in, no_erase_in, status_rd_in;
    efs_size_t        acc_size_in;
    logic [ADDR_W-1:0] acc_addr_in;
    logic [31:0]      acc_wdata_in, acc_rdata_out, seed = 32'hd34f_a8e8;
    logic [3:0]       cmd_code_in;
    logic [9:0]       cmd_page_in;
    logic [1:0]       wait_states_in;
    logic             acc_done_out, ready_out, irq_out;
    logic             ready_irq_en_in, lock_irq_en_in, prog_irq_en_in;
    logic [31:0]      pd [2][PAGE_WORDS];
    logic [3:0]       bad [8] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hC, 4'hE};
    int               failures = 0;
    int               checked = 0;

    efs_if bus_if ();
    efs_ctrl i_efs_ctrl (.sys_clk_in, .reset_in, .bus(bus_if), .irq_out, .ready_irq_en_in,
                         .lock_irq_en_in, .prog_irq_en_in);
    efs_master i_efs_master (.sys_clk_in, .reset_in, .bus(bus_if), .acc_req_in, .acc_we_in,
        .acc_fetch_in, .acc_size_in, .acc_addr_in, .acc_wdata_in, .cmd_req_in, .cmd_code_in,
        .cmd_page_in, .wait_states_in, .no_erase_in, .status_rd_in, .acc_done_out,
        .acc_rdata_out, .ready_out);
    efs_asserts i_chk (.sys_clk_in, .reset_in, .req(bus_if.req), .we(bus_if.we),
        .fetch(bus_if.fetch), .ack(bus_if.ack), .cmd_wr(bus_if.cmd_wr),
        .cmd_data(bus_if.cmd_data), .wait_states(bus_if.wait_states),
        .status_rd(bus_if.status_rd), .ready(bus_if.ready), .prog_err(bus_if.prog_err),
        .lock_err(bus_if.lock_err), .lock_status(bus_if.lock_status));

    always #10 sys_clk_in = ~sys_clk_in;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int fetch_cyc(int ws, int k);
        if (ws == 0) return 0;
        if (ws == 1) return (k == 0) ? 1 : 0;
        return (k % 2 == 0) ? ws : 0;
    endfunction
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_val(what, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic chk_cyc(input string what, input int exp, input int got);
        checked++;
        if (got != exp) begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk_in);
        #1;
    endtask
    // Request is held across back-to-back accesses so that fetch runs stay sequential.
    task automatic acc(input logic w, f, input efs_size_t sz, input logic [19:0] a,
                       input logic [31:0] d, input logic last, output logic [31:0] q,
                       output int n);
        if (acc_req_in === 1'b0) tick(1);
        acc_req_in = 1'b1;
        acc_we_in = w;
        acc_fetch_in = f;
        acc_size_in = sz;
        acc_addr_in = a;
        acc_wdata_in = d;
        n = 0;
        @(negedge sys_clk_in);
        while (acc_done_out !== 1'b1 && n < 20) begin
            @(negedge sys_clk_in);
            n++;
        end
        tick(1);
        q = acc_rdata_out;
        if (last) acc_req_in = 1'b0;
    endtask
    task automatic fill(input int sel);
        logic [31:0] q;
        int n;
        for (int i = 0; i < PAGE_WORDS; i++) begin
            wait_states_in = 2'(i % 4);
            pd[sel][i] = xs();
            acc(1, 0, EFS_SIZE_WORD, {12'(xs()), 6'(i), 2'b00}, pd[sel][i], 1, q, n);
            chk_cyc("write waits", (i % 4 == 3) ? 3 : i % 4 + 1, n);
        end
    endtask
    task automatic rd_page(input logic [9:0] p, input int sel);
        logic [31:0] q;
        int n;
        for (int i = 0; i < PAGE_WORDS; i++) begin
            wait_states_in = 2'(i % 4);
            acc(0, 0, EFS_SIZE_WORD, {2'(xs()), p, 6'(i), 2'b00}, 0, 1, q, n);
            chk_val("read data", pd[sel][i], q);
            chk_cyc("read waits", i % 4, n);
        end
    endtask
    task automatic issue(input logic [3:0] c, input logic [9:0] p);
        tick(1);
        cmd_code_in = c;
        cmd_page_in = p;
        cmd_req_in = 1'b1;
        tick(1);
        cmd_req_in = 1'b0;
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        while (ready_out === 1'b1 && k < 4) begin
            tick(1);
            k++;
        end
        chk_bit("ready low", 1'b0, ready_out);
        while (ready_out !== 1'b1 && k < 20000) begin
            tick(1);
            k++;
        end
        chk_bit("ready high", 1'b1, ready_out);
    endtask
    task automatic run(input logic [3:0] c, input logic [9:0] p);
        issue(c, p);
        wait_done();
    endtask
    task automatic srd();
        tick(1);
        status_rd_in = 1'b1;
        tick(1);
        status_rd_in = 1'b0;
        tick(2);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] q;
        int n;
        {acc_req_in, acc_we_in, acc_fetch_in, cmd_req_in, no_erase_in, status_rd_in} = '0;
        {ready_irq_en_in, lock_irq_en_in, prog_irq_en_in} = '0;
        {acc_addr_in, acc_wdata_in, cmd_code_in, cmd_page_in, wait_states_in} = '0;
        acc_size_in = EFS_SIZE_WORD;
        reset_in = 1'b1;
        tick(4);
        reset_in = 1'b0;
        tick(1);
        ready_irq_en_in = 1'b1;
        tick(1);
        chk_bit("ready irq", 1'b1, irq_out);
        ready_irq_en_in = 1'b0;
        fill(0);
        run(CMD_WRITE_PAGE, 10'h5);
        rd_page(10'h5, 0);
        for (int k = 0; k < 4; k++) begin
            acc(0, 0, EFS_SIZE_BYTE, {2'b00, 10'h5, 6'h3, 2'(k)}, 0, 1, q, n);
            chk_val("byte", {24'h0, pd[0][3][8*k+:8]}, q);
            acc(0, 0, EFS_SIZE_HALF, {2'b00, 10'h5, 6'h3, 2'(k & 2)}, 0, 1, q, n);
            chk_val("half", {16'h0, pd[0][3][16*(k/2)+:16]}, q);
        end
        for (int ws = 0; ws < 4; ws++) begin
            wait_states_in = 2'(ws);
            for (int k = 0; k < 6; k++) begin
                acc(0, 1, EFS_SIZE_WORD, {2'b00, 10'h5, 6'(k), 2'b00}, 0, k == 5, q, n);
                chk_val("fetch data", pd[0][k], q);
                chk_cyc("fetch waits", fetch_cyc(ws, k), n);
            end
        end
        issue(CMD_LOCK, 10'h5);
        acc(0, 0, EFS_SIZE_WORD, {2'b00, 10'h5, 6'h7, 2'b00}, 0, 1, q, n);
        chk_val("read while locking", pd[0][7], q);
        wait_done();
        chk_bit("locked", 1'b1, bus_if.lock_status[0]);
        fill(1);
        run(CMD_WRITE_PAGE, 10'h5);
        chk_bit("lock err", 1'b1, bus_if.lock_err);
        srd();
        chk_bit("lock err clear", 1'b0, bus_if.lock_err);
        lock_irq_en_in = 1'b1;
        run(CMD_ERASE_ALL, 10'h0);
        chk_bit("erase refused", 1'b1, bus_if.lock_err);
        chk_bit("lock irq", 1'b1, irq_out);
        srd();
        rd_page(10'h5, 0);
        run(CMD_UNLOCK, 10'h5);
        chk_bit("unlocked", 1'b0, bus_if.lock_status[0]);
        run(CMD_WRITE_LOCK, 10'h46);
        chk_bit("auto lock", 1'b1, bus_if.lock_status[1]);
        rd_page(10'h46, 1);
        run(CMD_UNLOCK, 10'h46);
        fill(1);
        issue(CMD_WRITE_PAGE, 10'h5);
        issue(CMD_LOCK, 10'h5);
        wait_done();
        chk_bit("lock ignored", 1'b0, bus_if.lock_status[0]);
        rd_page(10'h5, 1);
        prog_irq_en_in = 1'b1;
        foreach (bad[i]) begin
            run(bad[i], 10'h0);
            chk_bit("prog err", 1'b1, bus_if.prog_err);
            chk_bit("prog irq", 1'b1, irq_out);
            srd();
            chk_bit("prog err clear", 1'b0, bus_if.prog_err);
        end
        run(CMD_SET_GP, 10'h1);
        chk_val("gp set", 32'h2, {29'h0, bus_if.gp_bits});
        run(CMD_CLR_GP, 10'h1);
        chk_val("gp clear", 32'h0, {29'h0, bus_if.gp_bits});
        run(CMD_ERASE_ALL, 10'h0);
        acc(0, 0, EFS_SIZE_WORD, {2'b00, 10'h5, 6'h0, 2'b00}, 0, 1, q, n);
        chk_val("erased", ERASED_WORD, q);
        no_erase_in = 1'b1;
        fill(0);
        run(CMD_WRITE_PAGE, 10'h5);
        rd_page(10'h5, 0);
        run(CMD_SECURE, 10'h0);
        chk_bit("secure", 1'b1, bus_if.secure);
        stop_test();
    end

    // The whole sequence needs well under 60k cycles; this leaves ample margin.
    initial begin
        #(20 * 90000);
        failures++;
        stop_test();
    end
endmodule // embedded_flash_sequencer_tb
